// File: acquisition_source.sv
// Behavioural acquisition source that offers one sample per acquisition period.
module acquisition_source
#(
   parameter int PERIOD = 6
)
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic        run,
   input  wire logic [23:0] nextPressure,
   input  wire logic [15:0] nextTemp,
   output logic             sampleValid,
   output logic [23:0]      samplePressure,
   output logic [15:0]      sampleTemp,
   output logic [7:0]       issued
);
   timeunit 1ns;
   timeprecision 1ps;
   int unsigned phase;
   // The converter never waits for the queue, so a full queue simply loses samples.
   always @(negedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         phase <= 0;
         sampleValid <= 1'b0;
         samplePressure <= 24'h000000;
         sampleTemp <= 16'h0000;
         issued <= 8'h00;
      end
      else if (run && phase == PERIOD - 1)
      begin
         phase <= 0;
         sampleValid <= 1'b1;
         samplePressure <= nextPressure;
         sampleTemp <= nextTemp;
         issued <= issued + 8'h01;
      end
      else
      begin
         // Data is scrambled between pulses so that a late capture cannot pass.
         phase <= run ? phase + 1 : 0;
         sampleValid <= 1'b0;
         samplePressure <= ~samplePressure;
         sampleTemp <= ~sampleTemp;
      end
   end
endmodule // acquisition_source

// File: queue_buffer.sv
// Parameterised word FIFO with a registered head word.
module queue_buffer
#(
   parameter int WIDTH = 40,
   parameter int DEPTH = 4,
   localparam int AW = $clog2(DEPTH),
   localparam int CW = $clog2(DEPTH + 1)
)
(
   input  wire logic    clock,
   input  wire logic    rstn,
   input  wire logic    flush,
   stream_if.sink       inPort,
   stream_if.source     outPort,
   output logic [CW-1:0] count
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] headData;
   logic [AW-1:0]    wrPtr;
   logic [AW-1:0]    rdPtr;
   logic             space;
   wire              pop = outPort.valid && outPort.ready;
   // A full buffer still takes a word in the cycle it gives one away.
   wire              push = inPort.valid && (space || pop);
   wire [AW-1:0]     rdNext = AW'(rdPtr + 1'b1);
   wire [CW-1:0]     next_count = CW'(count + CW'(push) - CW'(pop));
   wire              headLoad = push && (count == '0 || (count == CW'(1) && pop));

   assign outPort.valid = count != '0;
   assign outPort.data  = headData;
   assign inPort.ready  = space;

   always_ff @(posedge clock)
   begin
      if (push)
         mem[wrPtr] <= inPort.data;
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         wrPtr    <= '0;
         rdPtr    <= '0;
         count    <= '0;
         space    <= 1'b1;
         headData <= '0;
      end
      else if (flush)
      begin
         wrPtr    <= '0;
         rdPtr    <= '0;
         count    <= '0;
         space    <= 1'b1;
         headData <= '0;
      end
      else
      begin
         wrPtr <= push ? AW'(wrPtr + 1'b1) : wrPtr;
         rdPtr <= pop ? rdNext : rdPtr;
         count <= next_count;
         space <= next_count != CW'(DEPTH);
         if (headLoad)
            headData <= inPort.data;
         else if (pop)
            headData <= mem[rdNext];
      end
   end

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   property p_count_bound;
      count <= CW'(DEPTH);
   endproperty
   a_count_bound: assert property (p_count_bound) else $error("count above depth");

   property p_space_full;
      !flush |=> (space == (count != CW'(DEPTH)));
   endproperty
   a_space_full: assert property (p_space_full) else $error("ready disagrees with count");
endmodule // queue_buffer

// File: sensor_fifo_pkg.sv
// Shared register map, field layout, sizes and encodings of the sample queue.
package sensor_fifo_pkg;
   localparam logic [7:0] ADDR_PRESS_HIGH = 8'h01;
   localparam logic [7:0] ADDR_TEMP_LOW   = 8'h05;
   localparam logic [7:0] ADDR_DELTA_HIGH = 8'h0a;
   localparam logic [7:0] ADDR_DELTA_LOW  = 8'h0b;
   localparam logic [7:0] ADDR_IDENTITY   = 8'h0c;
   localparam logic [7:0] ADDR_STATUS     = 8'h0d;
   localparam logic [7:0] ADDR_DATA_PORT  = 8'h0e;
   localparam logic [7:0] ADDR_SETUP      = 8'h0f;
   // Arbitrary neutral identity value; the real one comes from fuses.
   localparam logic [7:0] IDENTITY_DEFAULT = 8'h5a;
   localparam logic [7:0] REG_RESET        = 8'h00;
   localparam int STORE_DEPTH  = 32;
   localparam int STAGE_DEPTH  = 4;
   localparam int SAMPLE_WIDTH = 40;
   localparam int COUNT_WIDTH  = 6;
   localparam int DELTA_WIDTH  = 12;
   localparam int TEMP_WIDTH   = 16;
   localparam int PRESS_WIDTH  = 24;
   localparam int MODE_HI      = 7;
   localparam int MODE_LO      = 6;
   localparam int THR_HI       = 5;
   localparam int OVF_BIT      = 7;
   localparam int THR_FLAG_BIT = 6;
   localparam int TEMP_FRAC_LO = 4;
   localparam logic [3:0] RESERVED_NIBBLE = 4'h0;
   typedef enum logic [1:0] {
      MODE_OFF      = 2'b00,
      MODE_CIRCULAR = 2'b01,
      MODE_STOP     = 2'b10,
      MODE_UNUSED   = 2'b11
   } queue_mode_t;
   typedef enum logic [2:0] {
      BYTE_PRESS_HIGH,
      BYTE_PRESS_MID,
      BYTE_PRESS_LOW,
      BYTE_TEMP_HIGH,
      BYTE_TEMP_LOW
   } byte_pos_t;
endpackage

// File: sensor_sample_fifo_and_delta_regs_bench.sv
// Self-checking bench of the sample queue and its registers.
`define CHECK(got, exp) begin cmpCount++; if ((got) !== (exp)) begin errTotal++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module sensor_sample_fifo_and_delta_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary identity value.
   localparam logic [7:0] ID = 8'h3c;
   localparam logic [7:0] ADDRS[7] = '{8'h0a, 8'h0b, 8'h0d, 8'h0e, 8'h0f, 8'h01, 8'h30};
   logic        clock = 1'b0;
   logic        rstn = 1'b0;
   logic [7:0]  regAddr = 8'h00;
   logic        regRead = 1'b0;
   logic        regWrite = 1'b0;
   logic [7:0]  regWriteData = 8'h00;
   logic [7:0]  regReadData;
   logic        sampleValid;
   logic [23:0] samplePressure;
   logic [15:0] sampleTemp;
   logic        sampleReady;
   logic        rawMode = 1'b0;
   logic        deviceActive = 1'b0;
   logic        queueEvent;
   logic        queueEnabled;
   logic        run = 1'b0;
   logic [7:0]  issued;
   logic [7:0]  base = 8'h00;
   logic        taken = 1'b0;
   logic [7:0]  expQ[$];
   logic [7:0]  expByte;
   int          errTotal = 0;
   int          cmpCount = 0;
   int          cycles = 0;
   always #12.5 clock = ~clock;
   function automatic logic [23:0] pressOf(input logic [7:0] k);
      return {base, k, base ^ k};
   endfunction
   function automatic logic [15:0] tempOf(input logic [7:0] k);
      return {base ^ (k * 8'h25), k[3:0] ^ base[3:0], 4'h0};
   endfunction
   sensor_sample_queue #(.IDENTITY(ID)) i_sensor_sample_queue (.clock(clock), .rstn(rstn),
      .regAddr(regAddr), .regRead(regRead), .regWrite(regWrite), .regWriteData(regWriteData),
      .regReadData(regReadData), .sampleValid(sampleValid), .samplePressure(samplePressure),
      .sampleTemp(sampleTemp), .sampleReady(sampleReady), .rawMode(rawMode),
      .deviceActive(deviceActive), .queueEvent(queueEvent), .queueEnabled(queueEnabled));
   acquisition_source i_acquisition_source (.clock(clock), .rstn(rstn), .run(run),
      .nextPressure(pressOf(issued)), .nextTemp(tempOf(issued)), .sampleValid(sampleValid),
      .samplePressure(samplePressure), .sampleTemp(sampleTemp), .issued(issued));
   task automatic stopTest();
      if (errTotal == 0 && cmpCount > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      regRead = 1'b1;
      regAddr = a;
      expQ.push_back(e);
   endtask
   task automatic idle();
      @(negedge clock);
      regRead = 1'b0;
      regWrite = 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock);
      regWrite = 1'b1;
      regAddr = a;
      regWriteData = d;
      idle();
   endtask
   task automatic rdSample(input logic [7:0] k, input logic [7:0] a);
      logic [23:0] p;
      logic [15:0] t;
      p = pressOf(k);
      t = tempOf(k);
      rd(a, p[23:16]);
      rd(a, p[15:8]);
      rd(a, p[7:0]);
      rd(a, t[15:8]);
      rd(a, t[7:0]);
   endtask
   task automatic chkDelta(input logic [7:0] k);
      logic [15:0] a;
      logic [15:0] b;
      logic [11:0] d;
      a = tempOf(k);
      b = tempOf(k - 8'h01);
      d = a[15:4] - b[15:4];
      rd(8'h0a, d[11:4]);
      rd(8'h0b, {d[3:0], 4'h0});
      idle();
   endtask
   task automatic sendN(input int n);
      logic [7:0] target;
      target = issued + 8'(n);
      @(negedge clock);
      run <= 1'b1;
      while (issued !== target)
         @(negedge clock);
      run <= 1'b0;
      repeat (6) @(negedge clock);
   endtask
   task automatic setActive(input logic v);
      @(negedge clock);
      deviceActive = v;
      repeat (3) @(negedge clock);
   endtask
   // Read answers are noted in order and compared half a cycle after each read edge.
   always @(posedge clock)
      taken <= regRead;
   // The note is taken off once, so a mismatch cannot shift the later notes.
   always @(negedge clock)
      if (taken)
      begin
         expByte = expQ.pop_front();
         `CHECK(regReadData, expByte)
      end
   always @(posedge clock)
   begin
      cycles <= cycles + 1;
      if (cycles == 6000)
      begin
         errTotal++;
         stopTest();
      end
   end
   initial
   begin
      base = 8'($urandom(23895));
      repeat (20) @(negedge clock);
      rstn = 1'b1;
      `CHECK(sampleReady, 1'b1)
      foreach (ADDRS[i])
         rd(ADDRS[i], 8'h00);
      rd(8'h0c, ID);
      idle();
      wr(8'h0c, ~ID);
      rd(8'h0c, ID);
      idle();
      setActive(1'b1);
      sendN(2);
      chkDelta(8'h01);
      rawMode = 1'b1;
      sendN(1);
      chkDelta(8'h01);
      rawMode = 1'b0;
      setActive(1'b0);
      wr(8'h0f, 8'h83);
      rd(8'h0f, 8'h83);
      idle();
      setActive(1'b1);
      sendN(4);
      chkDelta(8'h06);
      `CHECK(queueEnabled, 1'b1)
      `CHECK(queueEvent, 1'b1)
      rd(8'h0d, 8'h44);
      idle();
      `CHECK(queueEvent, 1'b0)
      fork
         sendN(3);
         begin
            rdSample(8'h03, 8'h0e);
            rdSample(8'h04, 8'h01);
            for (int a = 2; a <= 5; a++)
               rd(8'(a), 8'h00);
            idle();
         end
      join
      rd(8'h0d, 8'h45);
      idle();
      sendN(29);
      rd(8'h0d, 8'he0);
      rdSample(8'h05, 8'h0e);
      rd(8'h0d, 8'h5f);
      idle();
      wr(8'h0f, 8'h43);
      rd(8'h0f, 8'h83);
      idle();
      wr(8'h0f, 8'h00);
      rd(8'h0d, 8'h00);
      rd(8'h0e, 8'h00);
      rd(8'h0d, 8'h00);
      idle();
      `CHECK(queueEnabled, 1'b0)
      wr(8'h0f, 8'hc0);
      rd(8'h0f, 8'hc3);
      rd(8'h01, 8'h00);
      idle();
      `CHECK(queueEnabled, 1'b0)
      setActive(1'b0);
      wr(8'h0f, 8'h40);
      setActive(1'b1);
      sendN(34);
      rd(8'h0d, 8'ha0);
      rdSample(8'd41, 8'h0e);
      idle();
      repeat (3) @(negedge clock);
      stopTest();
   end
endmodule // sensor_sample_fifo_and_delta_regs_bench

// File: sensor_sample_queue.sv
// Sample queue, delta, identity, status and setup registers of the sensor.
module sensor_sample_queue
#(
   parameter logic [7:0] IDENTITY = sensor_fifo_pkg::IDENTITY_DEFAULT
)
(
   input  wire logic        clock,
   input  wire logic        rstn,
   input  wire logic [7:0]  regAddr,
   input  wire logic        regRead,
   input  wire logic        regWrite,
   input  wire logic [7:0]  regWriteData,
   output logic [7:0]       regReadData,
   input  wire logic        sampleValid,
   input  wire logic [23:0] samplePressure,
   input  wire logic [15:0] sampleTemp,
   output logic             sampleReady,
   input  wire logic        rawMode,
   input  wire logic        deviceActive,
   output logic             queueEvent,
   output logic             queueEnabled
);
   localparam int CW = sensor_fifo_pkg::COUNT_WIDTH;
   localparam int DW = sensor_fifo_pkg::DELTA_WIDTH;

   stream_if #(.WIDTH(sensor_fifo_pkg::SAMPLE_WIDTH)) stageIn ();
   stream_if #(.WIDTH(sensor_fifo_pkg::SAMPLE_WIDTH)) stageOut ();
   stream_if #(.WIDTH(sensor_fifo_pkg::SAMPLE_WIDTH)) storeIn ();
   stream_if #(.WIDTH(sensor_fifo_pkg::SAMPLE_WIDTH)) storeOut ();

   sensor_fifo_pkg::queue_mode_t mode;
   sensor_fifo_pkg::byte_pos_t   bytePos;
   sensor_fifo_pkg::byte_pos_t   next_bytePos;
   logic [CW-1:0]                threshold;
   logic [CW-1:0]                storeCount;
   logic [DW-1:0]                tempDelta;
   logic [DW-1:0]                prevTemp;
   logic                         overflowFlag;
   logic                         thresholdFlag;
   logic                         prevCause;
   logic                         activeSeen;
   logic [7:0]                   byteValue;

   // Register access decode.
   wire setupWrite  = regWrite && regAddr == sensor_fifo_pkg::ADDR_SETUP;
   wire statusRead  = regRead && regAddr == sensor_fifo_pkg::ADDR_STATUS;
   wire outDataAddr = regAddr >= sensor_fifo_pkg::ADDR_PRESS_HIGH
                      && regAddr <= sensor_fifo_pkg::ADDR_TEMP_LOW;
   wire pressHigh   = regAddr == sensor_fifo_pkg::ADDR_PRESS_HIGH;
   wire enabled     = mode == sensor_fifo_pkg::MODE_CIRCULAR
                      || mode == sensor_fifo_pkg::MODE_STOP;
   wire dataRead    = regRead && (regAddr == sensor_fifo_pkg::ADDR_DATA_PORT
                      || (enabled && pressHigh));

   // Setup write filtering.
   wire [1:0] newModeBits = regWriteData[sensor_fifo_pkg::MODE_HI:sensor_fifo_pkg::MODE_LO];
   wire [CW-1:0] newThreshold = regWriteData[sensor_fifo_pkg::THR_HI:0];
   // The two running modes cannot be swapped directly; any other change is taken.
   wire modeAllowed = newModeBits == sensor_fifo_pkg::MODE_OFF
                      || newModeBits == sensor_fifo_pkg::MODE_UNUSED
                      || mode == sensor_fifo_pkg::MODE_OFF
                      || mode == sensor_fifo_pkg::MODE_UNUSED
                      || newModeBits == mode;
   // Threshold only changes in standby, so a running count is never rejudged mid-run.
   wire thresholdAllowed = !deviceActive;

   // Flush control.
   wire activation = deviceActive && !activeSeen;
   wire flush      = !enabled || activation;

   // Queue data movement.
   // The store's registered ready is its not-full state, so no second compare is kept.
   wire storeFull  = !storeIn.ready;
   wire hostTaking = dataRead && storeOut.valid;
   wire lastByte   = bytePos == sensor_fifo_pkg::BYTE_TEMP_LOW;
   wire hostPop    = hostTaking && lastByte;
   wire arriving   = stageOut.valid && stageOut.ready;
   wire overflowEvent = arriving && storeFull;
   wire circPop    = overflowEvent && mode == sensor_fifo_pkg::MODE_CIRCULAR;
   wire stopDrop   = overflowEvent && mode == sensor_fifo_pkg::MODE_STOP;
   // A host pop leaves the store short of full in the very next cycle.
   wire stillFull  = storeFull && !hostPop;

   assign stageIn.valid = sampleValid && enabled;
   assign stageIn.data  = {samplePressure, sampleTemp};
   // A host pop holds back the transfer so that the head never moves twice per cycle.
   assign stageOut.ready = !hostPop;
   assign storeIn.valid  = arriving && !stopDrop;
   assign storeIn.data   = stageOut.data;
   assign storeOut.ready = hostPop || circPop;

   queue_buffer
   #(
      .WIDTH (sensor_fifo_pkg::SAMPLE_WIDTH),
      .DEPTH (sensor_fifo_pkg::STAGE_DEPTH)
   )
   stage
   (
      .clock   (clock),
      .rstn    (rstn),
      .flush   (flush),
      .inPort  (stageIn.sink),
      .outPort (stageOut.source),
      .count   ()
   );

   queue_buffer
   #(
      .WIDTH (sensor_fifo_pkg::SAMPLE_WIDTH),
      .DEPTH (sensor_fifo_pkg::STORE_DEPTH)
   )
   store
   (
      .clock   (clock),
      .rstn    (rstn),
      .flush   (flush),
      .inPort  (storeIn.sink),
      .outPort (storeOut.source),
      .count   (storeCount)
   );

   // Byte position within the head sample.
   always_comb
   begin
      next_bytePos = bytePos;
      if (flush || circPop)
         next_bytePos = sensor_fifo_pkg::BYTE_PRESS_HIGH;
      else if (hostTaking)
      begin
         case (bytePos)
            sensor_fifo_pkg::BYTE_PRESS_HIGH: next_bytePos = sensor_fifo_pkg::BYTE_PRESS_MID;
            sensor_fifo_pkg::BYTE_PRESS_MID:  next_bytePos = sensor_fifo_pkg::BYTE_PRESS_LOW;
            sensor_fifo_pkg::BYTE_PRESS_LOW:  next_bytePos = sensor_fifo_pkg::BYTE_TEMP_HIGH;
            sensor_fifo_pkg::BYTE_TEMP_HIGH:  next_bytePos = sensor_fifo_pkg::BYTE_TEMP_LOW;
            default:                          next_bytePos = sensor_fifo_pkg::BYTE_PRESS_HIGH;
         endcase
      end
   end

   // Head byte selection.
   always_comb
   begin
      case (bytePos)
         sensor_fifo_pkg::BYTE_PRESS_HIGH: byteValue = storeOut.data[39:32];
         sensor_fifo_pkg::BYTE_PRESS_MID:  byteValue = storeOut.data[31:24];
         sensor_fifo_pkg::BYTE_PRESS_LOW:  byteValue = storeOut.data[23:16];
         sensor_fifo_pkg::BYTE_TEMP_HIGH:  byteValue = storeOut.data[15:8];
         default:                          byteValue = storeOut.data[7:0];
      endcase
   end

   // Status and flags.
   wire thresholdHit = threshold != '0 && storeCount > threshold;
   wire cause        = overflowFlag || thresholdFlag;
   wire causeRise    = cause && !prevCause;
   wire [DW-1:0] newTemp = sampleTemp[sensor_fifo_pkg::TEMP_WIDTH-1:sensor_fifo_pkg::TEMP_FRAC_LO];
   wire deltaUpdate  = sampleValid && !rawMode;

   // Read data selection.
   wire [7:0] statusValue = {overflowFlag, thresholdFlag, storeCount};
   wire [7:0] setupValue  = {mode, threshold};
   wire [7:0] portValue   = storeOut.valid ? byteValue : 8'h00;
   wire [7:0] deltaHigh   = tempDelta[DW-1:sensor_fifo_pkg::TEMP_FRAC_LO];
   wire [7:0] deltaLow    = {tempDelta[sensor_fifo_pkg::TEMP_FRAC_LO-1:0],
                             sensor_fifo_pkg::RESERVED_NIBBLE};
   wire [7:0] readMux =
      dataRead                                   ? portValue   :
      (enabled && outDataAddr)                   ? 8'h00       :
      regAddr == sensor_fifo_pkg::ADDR_DELTA_HIGH ? deltaHigh   :
      regAddr == sensor_fifo_pkg::ADDR_DELTA_LOW  ? deltaLow    :
      regAddr == sensor_fifo_pkg::ADDR_IDENTITY   ? IDENTITY    :
      regAddr == sensor_fifo_pkg::ADDR_STATUS     ? statusValue :
      regAddr == sensor_fifo_pkg::ADDR_SETUP      ? setupValue  :
      8'h00;

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         mode      <= sensor_fifo_pkg::MODE_OFF;
         threshold <= '0;
      end
      else if (setupWrite)
      begin
         mode      <= modeAllowed ? sensor_fifo_pkg::queue_mode_t'(newModeBits) : mode;
         threshold <= thresholdAllowed ? newThreshold : threshold;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         tempDelta <= '0;
         prevTemp  <= '0;
      end
      else if (deltaUpdate)
      begin
         tempDelta <= DW'(newTemp - prevTemp);
         prevTemp  <= newTemp;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         overflowFlag  <= 1'b0;
         thresholdFlag <= 1'b0;
         activeSeen    <= 1'b0;
         bytePos       <= sensor_fifo_pkg::BYTE_PRESS_HIGH;
      end
      else
      begin
         // The flag drops as soon as a read frees a slot.
         overflowFlag  <= !flush && (overflowEvent || (overflowFlag && stillFull));
         thresholdFlag <= !flush && thresholdHit;
         activeSeen    <= deviceActive;
         bytePos       <= next_bytePos;
      end
   end

   always_ff @(posedge clock or negedge rstn)
   begin
      if (!rstn)
      begin
         prevCause    <= 1'b0;
         queueEvent   <= 1'b0;
         regReadData  <= sensor_fifo_pkg::REG_RESET;
         queueEnabled <= 1'b0;
      end
      else
      begin
         prevCause    <= cause;
         // A new cause in the clearing cycle wins over the status read.
         queueEvent   <= causeRise || (queueEvent && !statusRead);
         regReadData  <= regRead ? readMux : regReadData;
         queueEnabled <= enabled;
      end
   end

   assign sampleReady = stageIn.ready;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   sequence s_status_read;
      regRead && regAddr == sensor_fifo_pkg::ADDR_STATUS;
   endsequence

   sequence s_identity_read;
      regRead && regAddr == sensor_fifo_pkg::ADDR_IDENTITY;
   endsequence

   property p_delta_tracks;
      deltaUpdate |=> tempDelta == DW'($past(newTemp) - $past(prevTemp));
   endproperty
   a_delta_tracks: assert property (p_delta_tracks) else $error("delta not updated");

   property p_raw_hold;
      sampleValid && rawMode |=> $stable(tempDelta) && $stable(prevTemp);
   endproperty
   a_raw_hold: assert property (p_raw_hold) else $error("delta moved in raw mode");

   property p_delta_when_off;
      deltaUpdate && !enabled |=> prevTemp == $past(newTemp);
   endproperty
   a_delta_when_off: assert property (p_delta_when_off) else $error("delta idle with queue off");

   property p_identity;
      s_identity_read |=> regReadData == IDENTITY;
   endproperty
   a_identity: assert property (p_identity) else $error("identity read wrong");

   property p_overflow;
      overflowEvent && !flush |=> overflowFlag ##1 (overflowFlag || !storeFull || flush);
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow flag not held");

   property p_threshold;
      !flush |=> thresholdFlag == $past(thresholdHit);
   endproperty
   a_threshold: assert property (p_threshold) else $error("threshold flag wrong");

   property p_threshold_zero;
      threshold == '0 |=> !thresholdFlag;
   endproperty
   a_threshold_zero: assert property (p_threshold_zero) else $error("flag with zero threshold");

   property p_event_clear;
      s_status_read ##0 !causeRise |=> !queueEvent;
   endproperty
   a_event_clear: assert property (p_event_clear) else $error("status read kept event");

   property p_other_zero;
      regRead && enabled && outDataAddr && !pressHigh |=> regReadData == 8'h00;
   endproperty
   a_other_zero: assert property (p_other_zero) else $error("output address not zero");

   property p_flush;
      !enabled |=> storeCount == '0 && !overflowFlag && !thresholdFlag;
   endproperty
   a_flush: assert property (p_flush) else $error("queue not cleared when off");

   property p_pop_count;
      hostPop && !storeIn.valid && !flush |=> storeCount == CW'($past(storeCount) - 1'b1);
   endproperty
   a_pop_count: assert property (p_pop_count) else $error("count not decremented");

   property p_empty_read;
      dataRead && storeCount == '0 && !storeIn.valid
         |=> regReadData == 8'h00 && storeCount == '0;
   endproperty
   a_empty_read: assert property (p_empty_read) else $error("empty read not zero");

   property p_intake;
      thresholdFlag && arriving && !storeFull && !flush
         |=> storeCount == CW'($past(storeCount) + 1'b1);
   endproperty
   a_intake: assert property (p_intake) else $error("intake stopped past threshold");

   property p_stop_hold;
      stopDrop && !flush |=> storeCount == $past(storeCount) && overflowFlag;
   endproperty
   a_stop_hold: assert property (p_stop_hold) else $error("stop mode took a sample");
endmodule // sensor_sample_queue

// File: stream_if.sv
// Valid/ready word stream between the queue's own modules.
interface stream_if #(parameter int WIDTH = 40) ();
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface
